// >>> hdl/umcre_defines.svh
// register map, field positions, reset values and timing counts
`ifndef UMCRE_DEFINES_SVH
`define UMCRE_DEFINES_SVH

`define UMCRE_ADDR_MODE     16'hff50
`define UMCRE_ADDR_RXBUF    16'hff51
`define UMCRE_ADDR_TXBUF    16'hff52
`define UMCRE_ADDR_ERRFLAGS 16'hff53
`define UMCRE_ADDR_TXSTAT   16'hff55

`define UMCRE_BIT_POWER     7
`define UMCRE_BIT_TX_EN     6
`define UMCRE_BIT_RX_EN     5
`define UMCRE_BIT_PAR_HI    4
`define UMCRE_BIT_PAR_LO    3
`define UMCRE_BIT_CHAR_LEN  2
`define UMCRE_BIT_STOP_SEL  1
`define UMCRE_BIT_ERR_ROUTE 0

`define UMCRE_BIT_PARITY_ERR  2
`define UMCRE_BIT_FRAMING_ERR 1
`define UMCRE_BIT_OVERRUN_ERR 0

`define UMCRE_BIT_TXBUF_FULL  1
`define UMCRE_BIT_TXSH_BUSY   0

`define UMCRE_RST_MODE      8'h01
`define UMCRE_RST_ERRFLAGS  3'h0
`define UMCRE_RST_BUF       8'hff
`define UMCRE_RST_TXSHIFT   12'hfff

`define UMCRE_PAR_NONE      2'h0
`define UMCRE_PAR_ZERO      2'h1
`define UMCRE_PAR_ODD       2'h2
`define UMCRE_PAR_EVEN      2'h3

// sample ticks per bit is 16: last tick of a bit and mid-bit tick
`define UMCRE_TICK_LAST     4'hf
`define UMCRE_TICK_MID      4'h7

`endif

// >>> hdl/umcre_pkg.sv
// types shared by the serial port mode and receive-error logic
package umcre_pkg;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'h0,
    RX_START = 2'h1,
    RX_DATA  = 2'h3,
    RX_STOP  = 2'h2
  } umcre_rx_state_t;

  typedef struct packed {
    logic [7:0]      mode;
    logic [2:0]      err;
    logic [7:0]      rx_buffer;
    logic            rx_full;
    logic [7:0]      tx_buffer;
    logic            txb_full;
    logic [11:0]     tx_sh;
    logic [3:0]      tx_cnt;
    logic [3:0]      tx_tick;
    umcre_rx_state_t rx_st;
    logic [3:0]      rx_tick;
    logic [3:0]      rx_bit;
    logic [8:0]      rx_sh;
    logic [7:0]      rdata;
    logic            irq_done;
    logic            irq_err;
  } umcre_state_t;

  typedef struct packed {
    logic meta;
    logic sync;
  } umcre_sync_state_t;

endpackage : umcre_pkg

// >>> hdl/umcre_sync.sv
// two flip-flop synchroniser for an input from outside the clock domain
`timescale 1ns/1ps
module umcre_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // asynchronous input and its synchronised copy
  input  wire logic async_i,
  output logic      sync_o
);

  umcre_pkg::umcre_sync_state_t s;
  umcre_pkg::umcre_sync_state_t next_s;

  always_comb begin
    next_s.meta = async_i;
    next_s.sync = s.meta;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '{meta: 1'b1, sync: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign sync_o = s.sync;

endmodule : umcre_sync

// >>> hdl/umcre_top.sv
// serial port mode control, transmit/receive framing and receive errors
// Notes on behaviour
// - power bit low stops and resets port
// - power off resets error, status, receive buffer
// - transmit enable low resets transmit circuitry
// - receive enable low resets receive circuitry
// - power off: output high, receive input high
// - parity field: none, zero, odd, even
// - zero parity never flags parity errors
// - character length seven or eight bits
// - transmitter sends one or two stop bits
// - receiver checks only one stop bit
// - route bit picks error or done interrupt
// - mode register resets to 01h
// - enabling receive on low line starts reception
// - error flags clear when off or read
// - parity and framing errors set at completion
// - overrun sets flag, new byte discarded
// - seven-bit data reads top bit zero
`timescale 1ns/1ps
`include "umcre_defines.svh"
module umcre_top (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // register port
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic       cpu_wr_i,
  input  wire logic       cpu_rd_i,
  input  wire logic [7:0] cpu_wdata_i,
  output logic      [7:0] cpu_rdata_o,
  // sixteen-per-bit sample tick from the baud generator
  input  wire logic       sample_tick_i,
  // serial pins
  input  wire logic       serial_in_pin_i,
  output logic            serial_out_pin_o,
  // interrupt pulses
  output logic            rx_done_irq_o,
  output logic            rx_error_irq_o
);

  umcre_pkg::umcre_state_t s;
  umcre_pkg::umcre_state_t next_s;

  logic       rx_pin_sync;
  logic       port_power_on;
  logic       tx_enable;
  logic       rx_enable;
  logic [1:0] parity_sel;
  logic       char_len_sel;
  logic       stop_bits_sel;
  logic       err_irq_route;
  logic       rx_line;
  logic [3:0] tx_len;
  logic [3:0] rx_nbits;
  logic [3:0] rx_par_idx;
  logic [7:0] rx_data;
  logic       rx_par_bad;
  logic       rx_frame_bad;
  logic       rx_overrun;
  logic [7:0] tx_status;

  umcre_sync u_rx_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (serial_in_pin_i),
    .sync_o    (rx_pin_sync)
  );

  // keep only the selected data bits
  function automatic logic [7:0] sel_data(input logic [7:0] d,
                                          input logic       cl);
    sel_data = cl ? d : {1'b0, d[6:0]};
  endfunction : sel_data

  function automatic logic gen_parity(input logic [7:0] d,
                                      input logic [1:0] ps);
    logic p;
    p = ^d;
    case (ps)
      `UMCRE_PAR_ODD:  gen_parity = ~p;
      `UMCRE_PAR_EVEN: gen_parity = p;
      default:         gen_parity = 1'b0;
    endcase
  endfunction : gen_parity

  // start bit, data lsb first, optional parity, then idle-high stop bits
  function automatic logic [11:0] build_frame(input logic [7:0] d,
                                              input logic       cl,
                                              input logic [1:0] ps);
    logic [11:0] f;
    f    = `UMCRE_RST_TXSHIFT;
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < 7 || cl) begin
        f[i + 1] = d[i];
      end
    end
    if (ps != `UMCRE_PAR_NONE) begin
      f[cl ? 9 : 8] = gen_parity(sel_data(d, cl), ps);
    end
    build_frame = f;
  endfunction : build_frame

  assign port_power_on = s.mode[`UMCRE_BIT_POWER];
  assign tx_enable     = s.mode[`UMCRE_BIT_TX_EN];
  assign rx_enable     = s.mode[`UMCRE_BIT_RX_EN];
  assign parity_sel    = {s.mode[`UMCRE_BIT_PAR_HI],
                          s.mode[`UMCRE_BIT_PAR_LO]};
  assign char_len_sel  = s.mode[`UMCRE_BIT_CHAR_LEN];
  assign stop_bits_sel = s.mode[`UMCRE_BIT_STOP_SEL];
  assign err_irq_route = s.mode[`UMCRE_BIT_ERR_ROUTE];

  // with power off the receiver sees an idle line
  assign rx_line = port_power_on ? rx_pin_sync : 1'b1;

  // frame bits: start, 7 or 8 data, optional parity, 1 or 2 stop
  assign tx_len = 4'd9 + {3'h0, char_len_sel}
                + {3'h0, |parity_sel}
                + {3'h0, stop_bits_sel};
  // bits between start and the single checked stop bit
  assign rx_nbits   = 4'd7 + {3'h0, char_len_sel} + {3'h0, |parity_sel};
  assign rx_par_idx = char_len_sel ? 4'd8 : 4'd7;
  assign rx_data    = sel_data(s.rx_sh[7:0], char_len_sel);

  // only odd and even are judged; zero parity is never checked
  assign rx_par_bad = parity_sel[1] &&
                      (s.rx_sh[rx_par_idx] !=
                       gen_parity(rx_data, parity_sel));
  assign rx_frame_bad = ~rx_line;
  // a buffer read in the completing cycle avoids the overrun
  assign rx_overrun = s.rx_full &&
                      !(cpu_rd_i && cpu_addr_i == `UMCRE_ADDR_RXBUF);

  assign tx_status = {6'h00, s.txb_full, (s.tx_cnt != 4'h0)};

  always_comb begin
    next_s          = s;
    next_s.irq_done = 1'b0;
    next_s.irq_err  = 1'b0;

    // register reads; a read of the flags clears them, a read of the buffer clears rx_full
    if (cpu_rd_i) begin
      if (cpu_addr_i == `UMCRE_ADDR_MODE) begin
        next_s.rdata = s.mode;
      end else if (cpu_addr_i == `UMCRE_ADDR_ERRFLAGS) begin
        next_s.rdata = {5'h00, s.err};
        next_s.err   = `UMCRE_RST_ERRFLAGS;
      end else if (cpu_addr_i == `UMCRE_ADDR_RXBUF) begin
        next_s.rdata   = s.rx_buffer;
        next_s.rx_full = 1'b0;
      end else if (cpu_addr_i == `UMCRE_ADDR_TXBUF) begin
        next_s.rdata = s.tx_buffer;
      end else if (cpu_addr_i == `UMCRE_ADDR_TXSTAT) begin
        next_s.rdata = tx_status;
      end else begin
        next_s.rdata = 8'h00;
      end
    end

    // register writes
    if (cpu_wr_i) begin
      if (cpu_addr_i == `UMCRE_ADDR_MODE) begin
        next_s.mode = cpu_wdata_i;
      end else if (cpu_addr_i == `UMCRE_ADDR_TXBUF) begin
        next_s.tx_buffer = cpu_wdata_i;
        if (port_power_on && tx_enable) begin
          next_s.txb_full = 1'b1;
        end
      end
    end

    // transmitter
    if (s.tx_cnt == 4'h0) begin
      if (s.txb_full) begin
        next_s.tx_sh    = build_frame(s.tx_buffer, char_len_sel,
                                      parity_sel);
        next_s.tx_cnt   = tx_len;
        next_s.tx_tick  = 4'h0;
        next_s.txb_full = 1'b0;
      end
    end else if (sample_tick_i) begin
      next_s.tx_tick = s.tx_tick + 4'h1;
      if (s.tx_tick == `UMCRE_TICK_LAST) begin
        next_s.tx_sh  = {1'b1, s.tx_sh[11:1]};
        next_s.tx_cnt = s.tx_cnt - 4'h1;
      end
    end
    if (!tx_enable) begin
      next_s.tx_cnt   = 4'h0;
      next_s.tx_tick  = 4'h0;
      next_s.tx_sh    = `UMCRE_RST_TXSHIFT;
      next_s.txb_full = 1'b0;
    end

    // receiver
    case (s.rx_st)
      umcre_pkg::RX_IDLE: begin
        // level check, so a line already low starts a frame
        if (rx_enable && !rx_line) begin
          next_s.rx_st   = umcre_pkg::RX_START;
          next_s.rx_tick = 4'h0;
        end
      end
      umcre_pkg::RX_START: begin
        if (sample_tick_i) begin
          next_s.rx_tick = s.rx_tick + 4'h1;
          if (s.rx_tick == `UMCRE_TICK_MID) begin
            if (!rx_line) begin
              next_s.rx_st   = umcre_pkg::RX_DATA;
              next_s.rx_tick = 4'h0;
              next_s.rx_bit  = 4'h0;
              next_s.rx_sh   = 9'h000;
            end else begin
              next_s.rx_st = umcre_pkg::RX_IDLE;
            end
          end
        end
      end
      umcre_pkg::RX_DATA: begin
        if (sample_tick_i) begin
          next_s.rx_tick = s.rx_tick + 4'h1;
          if (s.rx_tick == `UMCRE_TICK_LAST) begin
            next_s.rx_sh[s.rx_bit] = rx_line;
            next_s.rx_bit          = s.rx_bit + 4'h1;
            if (s.rx_bit == rx_nbits - 4'h1) begin
              next_s.rx_st = umcre_pkg::RX_STOP;
            end
          end
        end
      end
      umcre_pkg::RX_STOP: begin
        if (sample_tick_i) begin
          next_s.rx_tick = s.rx_tick + 4'h1;
          if (s.rx_tick == `UMCRE_TICK_LAST) begin
            next_s.rx_st = umcre_pkg::RX_IDLE;
            if (rx_par_bad) begin
              next_s.err[`UMCRE_BIT_PARITY_ERR] = 1'b1;
            end
            if (rx_frame_bad) begin
              next_s.err[`UMCRE_BIT_FRAMING_ERR] = 1'b1;
            end
            // buffer still unread: flag and drop the new byte
            if (rx_overrun) begin
              next_s.err[`UMCRE_BIT_OVERRUN_ERR] = 1'b1;
            end else begin
              next_s.rx_buffer = rx_data;
              next_s.rx_full   = 1'b1;
            end
            if ((rx_par_bad || rx_frame_bad || rx_overrun)
                && !err_irq_route) begin
              next_s.irq_err = 1'b1;
            end else begin
              next_s.irq_done = 1'b1;
            end
          end
        end
      end
      default: begin
        next_s.rx_st = umcre_pkg::RX_IDLE;
      end
    endcase
    if (!rx_enable) begin
      next_s.rx_st   = umcre_pkg::RX_IDLE;
      next_s.rx_tick = 4'h0;
      next_s.rx_bit  = 4'h0;
      next_s.irq_err  = 1'b0;
      next_s.irq_done = 1'b0;
    end
    if (!port_power_on && !rx_enable) begin
      next_s.err = `UMCRE_RST_ERRFLAGS;
    end

    // power off holds the port in its initial state, except mode, tx_buffer and rdata
    if (!port_power_on) begin
      next_s.err       = `UMCRE_RST_ERRFLAGS;
      next_s.rx_buffer = `UMCRE_RST_BUF;
      next_s.rx_full   = 1'b0;
      next_s.txb_full  = 1'b0;
      next_s.tx_cnt    = 4'h0;
      next_s.tx_tick   = 4'h0;
      next_s.tx_sh     = `UMCRE_RST_TXSHIFT;
      next_s.rx_st     = umcre_pkg::RX_IDLE;
      next_s.rx_tick   = 4'h0;
      next_s.rx_bit    = 4'h0;
      next_s.rx_sh     = 9'h000;
      next_s.irq_done  = 1'b0;
      next_s.irq_err   = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s.mode      <= `UMCRE_RST_MODE;
      s.err       <= `UMCRE_RST_ERRFLAGS;
      s.rx_buffer <= `UMCRE_RST_BUF;
      s.rx_full   <= 1'b0;
      s.tx_buffer <= `UMCRE_RST_BUF;
      s.txb_full  <= 1'b0;
      s.tx_sh     <= `UMCRE_RST_TXSHIFT;
      s.tx_cnt    <= 4'h0;
      s.tx_tick   <= 4'h0;
      s.rx_st     <= umcre_pkg::RX_IDLE;
      s.rx_tick   <= 4'h0;
      s.rx_bit    <= 4'h0;
      s.rx_sh     <= 9'h000;
      s.rdata     <= 8'h00;
      s.irq_done  <= 1'b0;
      s.irq_err   <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign cpu_rdata_o      = s.rdata;
  assign serial_out_pin_o = s.tx_sh[0];
  assign rx_done_irq_o    = s.irq_done;
  assign rx_error_irq_o   = s.irq_err;

endmodule : umcre_top

// >>> verification/umcre_checker.sv
// port-level checks for the serial port mode and receive-error block
`timescale 1ns/1ps
module umcre_checker (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  // register port
  input wire logic [15:0] cpu_addr_i,
  input wire logic        cpu_wr_i,
  input wire logic        cpu_rd_i,
  input wire logic [7:0]  cpu_wdata_i,
  input wire logic [7:0]  cpu_rdata_o,
  // tick, pins and interrupts
  input wire logic        sample_tick_i,
  input wire logic        serial_in_pin_i,
  input wire logic        serial_out_pin_o,
  input wire logic        rx_done_irq_o,
  input wire logic        rx_error_irq_o
);
  logic [7:0] mode;
  logic       wrote;
  logic [2:0] txoff;
  logic [2:0] rxoff;
  logic [2:0] poff;
  logic       irq;
  logic       rd_err;
  assign irq    = rx_done_irq_o | rx_error_irq_o;
  assign rd_err = cpu_rd_i && cpu_addr_i == 16'hff53;
  // shadow of the mode register and how long each part has been off
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode  <= 8'h01;
      wrote <= 1'b0;
      txoff <= 3'h7;
      rxoff <= 3'h7;
      poff  <= 3'h7;
    end else begin
      if (cpu_wr_i && cpu_addr_i == 16'hff50) begin
        mode  <= cpu_wdata_i;
        wrote <= 1'b1;
      end
      txoff <= {txoff[1:0], !(mode[7] && mode[6])};
      rxoff <= {rxoff[1:0], !(mode[7] && mode[5])};
      poff  <= {poff[1:0], !mode[7]};
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  chk_irq_exclusive: assert property (!(rx_done_irq_o && rx_error_irq_o))
    else $error("both receive interrupts at once");
  chk_err_route: assert property (rx_error_irq_o |-> !mode[0])
    else $error("error interrupt while routed to done");
  chk_mode_reset: assert property (
    cpu_rd_i && cpu_addr_i == 16'hff50 && !wrote |=> cpu_rdata_o == 8'h01)
    else $error("mode reset value wrong");
  chk_flags_clear: assert property (
    rd_err && !irq ##1 rd_err && !irq |=> cpu_rdata_o == 8'h00)
    else $error("error flags not cleared by read");
  chk_tx_off_idle: assert property (&txoff |-> serial_out_pin_o)
    else $error("output pin low while transmit off");
  chk_rx_off_quiet: assert property (&rxoff |-> !irq)
    else $error("receive interrupt while receive off");
  chk_pwr_off_flags: assert property (
    &poff && rd_err |=> cpu_rdata_o == 8'h00)
    else $error("error flags set while powered off");
  chk_pwr_off_rxbuf: assert property (
    &poff && cpu_rd_i && cpu_addr_i == 16'hff51 |=> cpu_rdata_o == 8'hff)
    else $error("receive buffer not reset while powered off");
  cov_rx_done: cover property (rx_done_irq_o);
  cov_rx_error: cover property (rx_error_irq_o);
  cov_tx_start: cover property ($fell(serial_out_pin_o));
endmodule : umcre_checker

bind umcre_top umcre_checker i_checker (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .cpu_addr_i(cpu_addr_i),
  .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i), .cpu_wdata_i(cpu_wdata_i),
  .cpu_rdata_o(cpu_rdata_o), .sample_tick_i(sample_tick_i),
  .serial_in_pin_i(serial_in_pin_i), .serial_out_pin_o(serial_out_pin_o),
  .rx_done_irq_o(rx_done_irq_o), .rx_error_irq_o(rx_error_irq_o)
);

// >>> verification/umcre_remote_station.sv
// remote serial station: sends frames to the port and records its output
`timescale 1ns/1ps
module umcre_remote_station (
  // clock and sixteen-per-bit sample tick
  input  wire logic clk_i,
  input  wire logic tick_i,
  // serial lines seen from the remote side
  input  wire logic line_in_i,
  output logic      line_out_o
);
  initial line_out_o = 1'b1;
  // start bit, then n bits lsb first, sixteen ticks each
  task automatic send(input logic [12:0] b, input int n);
    logic [13:0] s;
    s = {b, 1'b0};
    for (int i = 0; i <= n; i++) begin
      line_out_o <= s[i];
      repeat (16) @(posedge clk_i iff tick_i);
    end
    line_out_o <= 1'b1;
  endtask : send
  // waits for a start bit, then samples n bits at mid-bit
  task automatic capture(output logic [12:0] b, input int n);
    int k;
    b = 13'h0000;
    for (k = 0; k < 4000 && line_in_i; k++) @(posedge clk_i);
    if (k == 4000) b = 'x;
    repeat (8) @(posedge clk_i iff tick_i);
    for (int i = 0; i < n; i++) begin
      repeat (16) @(posedge clk_i iff tick_i);
      b[i] = line_in_i;
    end
  endtask : capture
endmodule : umcre_remote_station

// >>> verification/test_uart_mode_control_and_rx_errors.sv
// bench for the serial port mode control and receive-error block
`timescale 1ns/1ps
module test_uart_mode_control_and_rx_errors;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [15:0] cpu_addr_i = 16'h0000;
  logic        cpu_wr_i = 1'b0;
  logic        cpu_rd_i = 1'b0;
  logic [7:0]  cpu_wdata_i = 8'h00;
  logic [7:0]  cpu_rdata_o;
  logic        tick = 1'b0;
  logic        rx_line;
  logic        tx_line;
  logic        done;
  logic        err;
  int          n_mismatch = 0;
  int          compares = 0;
  logic [7:0]  v;
  logic [12:0] f;
  logic [1:0]  q;
  always #5 clk_i = ~clk_i;
  // tick every other clock: one bit lasts 32 clocks
  always @(posedge clk_i) tick <= ~tick;
  umcre_top i_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .cpu_addr_i(cpu_addr_i),
    .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i), .cpu_wdata_i(cpu_wdata_i),
    .cpu_rdata_o(cpu_rdata_o), .sample_tick_i(tick),
    .serial_in_pin_i(rx_line), .serial_out_pin_o(tx_line),
    .rx_done_irq_o(done), .rx_error_irq_o(err)
  );
  umcre_remote_station i_remote (
    .clk_i(clk_i), .tick_i(tick), .line_in_i(tx_line), .line_out_o(rx_line)
  );
  task automatic results;
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      n_mismatch++;
      results;
    end
  endtask : tmo
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cpu_wr_i    <= 1'b1;
    cpu_addr_i  <= a;
    cpu_wdata_i <= d;
    @(posedge clk_i);
    cpu_wr_i <= 1'b0;
  endtask : wr
  task automatic rc(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_i);
    cpu_rd_i   <= 1'b1;
    cpu_addr_i <= a;
    @(posedge clk_i);
    cpu_rd_i <= 1'b0;
    #1 chk(cpu_rdata_o, e);
  endtask : rc
  // data bits, parity, first and optional second stop bit
  function automatic logic [12:0] fr(input logic [7:0] d, input logic c8,
                                     input logic [1:0] ps, input logic s2);
    logic [12:0] b;
    int i;
    b = 13'h0000;
    for (i = 0; i < 7 + c8; i++) b[i] = d[i];
    if (ps != 2'h0) begin
      b[i] = ps[1] & (^(d & {c8, 7'h7f}) ^ ~ps[0]);
      i++;
    end
    b[i] = 1'b1;
    b[i + 1] = s2;
    return b;
  endfunction : fr
  task automatic cfg(input logic [7:0] m);
    wr(16'hff50, {3'b100, m[4:0]});
    wr(16'hff50, m);
  endtask : cfg
  task automatic off(input logic [7:0] m);
    wr(16'hff50, {3'b100, m[4:0]});
    wr(16'hff50, 8'h00);
  endtask : off
  task automatic rx1(input logic [12:0] b, input int n);
    int k;
    fork
      i_remote.send(b, n);
      begin
        for (k = 0; k < 1000 && !(done | err); k++) begin
          @(posedge clk_i);
          #1;
        end
        q = {done, err};
        tmo(k, 1000);
      end
    join
  endtask : rx1
  task automatic t_rst;
    chk(tx_line, 1'b1);
    rc(16'hff50, 8'h01);
    rc(16'hff53, 8'h00);
    rc(16'hff51, 8'hff);
    rc(16'hff52, 8'hff);
    rc(16'hff54, 8'h00);
    wr(16'hff53, 8'h07);
    rc(16'hff53, 8'h00);
  endtask : t_rst
  task automatic t_tx(input logic [7:0] m, input logic [7:0] d);
    int n;
    int k;
    n = 9 + m[2] + (m[4:3] != 2'h0) + m[1];
    cfg(m);
    fork
      i_remote.capture(f, n);
      begin
        wr(16'hff52, d);
        for (k = 0; k < 400; k++) begin
          @(posedge clk_i);
          cpu_rd_i   <= 1'b1;
          cpu_addr_i <= 16'hff55;
          @(posedge clk_i);
          cpu_rd_i <= 1'b0;
          #1 v = cpu_rdata_o;
          if (v[1] === 1'b0) break;
        end
        tmo(k, 400);
        wr(16'hff52, ~d);
      end
    join
    chk(f, fr(d, m[2], m[4:3], m[1]));
    off(m);
  endtask : t_tx
  task automatic t_rx(input logic [7:0] m, input logic [7:0] d,
                      input logic fp, input logic bs, input logic [2:0] e);
    logic [12:0] b;
    int n;
    logic er;
    n = 8 + m[2] + (m[4:3] != 2'h0);
    b = fr(d, m[2], m[4:3], 1'b0);
    b[n - 2] = b[n - 2] ^ fp;
    b[n - 1] = ~bs;
    er = |e & ~m[0];
    cfg(m);
    rx1(b, n);
    chk(q, {~er, er});
    @(posedge clk_i);
    cpu_rd_i   <= 1'b1;
    cpu_addr_i <= 16'hff53;
    @(posedge clk_i);
    #1 chk(cpu_rdata_o, e);
    @(posedge clk_i);
    cpu_rd_i <= 1'b0;
    #1 chk(cpu_rdata_o, 8'h00);
    rc(16'hff51, {m[2] & d[7], d[6:0]});
    off(m);
  endtask : t_rx
  task automatic t_ovr;
    cfg(8'ha4);
    rx1(fr(8'h11, 1'b1, 2'h0, 1'b0), 9);
    rx1(fr(8'h22, 1'b1, 2'h0, 1'b0), 9);
    chk(q, 2'h1);
    rc(16'hff53, 8'h01);
    rc(16'hff51, 8'h11);
    off(8'ha4);
  endtask : t_ovr
  task automatic t_pwr;
    cfg(8'he5);
    rx1(fr(8'h81, 1'b1, 2'h0, 1'b0) & 13'h00ff, 9);
    wr(16'hff52, 8'h00);
    repeat (100) @(posedge clk_i);
    // power dropped mid-frame on purpose
    wr(16'hff50, 8'h00);
    repeat (3) @(posedge clk_i);
    #1 chk(tx_line, 1'b1);
    rc(16'hff53, 8'h00);
    rc(16'hff51, 8'hff);
    rc(16'hff55, 8'h00);
  endtask : t_pwr
  initial begin
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_rst;
    for (logic [2:0] i = 0; i < 4; i++) begin
      t_tx({3'b110, i[1:0], i[0], i[1], 1'b0}, 8'hb5);
    end
    t_rx(8'hbe, 8'h5a, 1'b0, 1'b0, 3'h0);
    t_rx(8'hb0, 8'hc3, 1'b1, 1'b0, 3'h4);
    t_rx(8'hac, 8'h3c, 1'b1, 1'b0, 3'h0);
    t_rx(8'ha5, 8'h81, 1'b0, 1'b1, 3'h2);
    t_ovr;
    t_pwr;
    results;
  end
endmodule : test_uart_mode_control_and_rx_errors
